// >>> residual_current_readout_port.sv
// readout port: measurement words, serial frame, bitstream and fault pin
`timescale 1ns/1ps
module residual_current_readout_port #(
    parameter int unsigned STARTUP_CYCLES = readout_pkg::STARTUP_CYC
) (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                reset_n,
    input  wire logic                mod_clk,
    input  wire logic                sclk,
    input  wire logic                ss_n,
    input  wire logic signed [15:0]  sense_code,
    input  wire logic signed [15:0]  test_code,
    input  wire logic                sample_strobe,
    input  wire readout_pkg::fault_t fault_in,
    output logic                     miso_o,
    output logic                     miso_oe_n,
    output logic                     bitstream_p,
    output logic                     bitstream_n,
    output logic                     fault_pin,
    output logic                     ready
);
    import readout_pkg::*;

    localparam int FAULT_HALF_I = FAULT_HALF_CYC;

    logic                resn_meta_reg;
    logic                resn_sync_reg;
    logic                ss_meta_reg;
    logic                ss_sync_reg;
    logic [31:0]         start_cnt_reg;
    logic                ready_reg;
    logic                hw_fault_reg;
    fault_t              flags;
    logic                err_any;
    logic signed [19:0]  sum;
    logic [15:0]         wide_reg;
    logic [23:0]         narrow_acc_reg;
    logic signed [24:0]  nb_diff;
    logic signed [24:0]  nb_sum;
    logic [15:0]         word1;
    frame_t              frame_reg;
    logic [15:0]         sd_word_reg;
    logic                sd_tog_reg;
    logic                sd_gap_reg;
    logic [8:0]          fault_cnt_reg;
    logic                fault_reg;
    logic                spi_arst;
    logic [5:0]          bit_cnt_reg;
    logic                miso_reg;
    logic [15:0]         since_tog_reg;

    // reset and select pins pass two flip-flops before core-clock logic looks at them
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            resn_meta_reg <= 1'b0;
            resn_sync_reg <= 1'b0;
            ss_meta_reg   <= 1'b1;
            ss_sync_reg   <= 1'b1;
        end
        else
        begin
            resn_meta_reg <= reset_n;
            resn_sync_reg <= resn_meta_reg;
            ss_meta_reg   <= ss_n;
            ss_sync_reg   <= ss_meta_reg;
        end
    end

    // start-up interval restarts on every reset pin pulse
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            start_cnt_reg <= 32'h0000_0000;
            ready_reg     <= 1'b0;
        end
        else if (!resn_sync_reg)
        begin
            start_cnt_reg <= 32'h0000_0000;
            ready_reg     <= 1'b0;
        end
        else if (!ready_reg)
        begin
            start_cnt_reg <= start_cnt_reg + 32'h0000_0001;
            if (start_cnt_reg == STARTUP_CYCLES - 1)
                ready_reg <= 1'b1;
        end
    end

    assign ready = ready_reg;

    // self-test failure is kept until power cycle, the reset pin keeps it
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            hw_fault_reg <= 1'b0;
        else if (ready_reg && fault_in.hw)
            hw_fault_reg <= 1'b1;
    end

    always_comb
    begin
        flags.hw         = hw_fault_reg;
        flags.over_range = ready_reg & fault_in.over_range;
        flags.critical   = ready_reg & fault_in.critical;
    end

    assign err_any = flags.hw | flags.over_range | flags.critical;

    // test coil has ten turns, so its current counts ten times
    assign sum = 20'(sense_code) + 20'(test_code) * 20'(TEST_GAIN);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            wide_reg <= MIDSCALE;
        else if (!ready_reg)
            wide_reg <= MIDSCALE;
        else if (sample_strobe)
            wide_reg <= to_offset(sum);
    end

    // one-pole low pass; shift of 8 at 16 kSa/s puts the corner near 10 Hz
    assign nb_diff = $signed({1'b0, wide_reg, 8'h00})
                   - $signed({1'b0, narrow_acc_reg});
    assign nb_sum  = $signed({1'b0, narrow_acc_reg}) + (nb_diff >>> NB_SHIFT);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            narrow_acc_reg <= {MIDSCALE, 8'h00};
        else if (!ready_reg)
            narrow_acc_reg <= {MIDSCALE, 8'h00};
        else if (sample_strobe)
            narrow_acc_reg <= nb_sum[23:0];
    end

    assign word1 = err_any ? err_word(flags) : wide_reg;

    // frame only moves while deselected; a change landing within the
    // synchroniser delay after select falls may tear the first bits
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            frame_reg <= FRAME_IDLE;
        else if (ss_sync_reg)
            frame_reg <= frame_build(word1, narrow_acc_reg[23:NB_FRAC]);
    end

    // modulator word: hold for a core cycle after each toggle
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sd_word_reg <= MIDSCALE;
            sd_tog_reg  <= 1'b0;
            sd_gap_reg  <= 1'b0;
        end
        else
        begin
            sd_gap_reg <= 1'b0;
            if (!sd_gap_reg && sd_word_reg != word1)
            begin
                sd_word_reg <= word1;
                sd_tog_reg  <= ~sd_tog_reg;
                sd_gap_reg  <= 1'b1;
            end
        end
    end

    sd_modulator u_mod (
        .mod_clk     (mod_clk),
        .rst         (rst),
        .word_in     (sd_word_reg),
        .word_toggle (sd_tog_reg),
        .bitstream_p (bitstream_p),
        .bitstream_n (bitstream_n)
    );

    // fault pin: frozen during start-up and on any fault
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            fault_cnt_reg <= 9'h000;
            fault_reg     <= 1'b0;
        end
        else if (!ready_reg || err_any)
        begin
            fault_cnt_reg <= 9'h000;
        end
        else if (fault_cnt_reg == 9'(FAULT_HALF_CYC - 1))
        begin
            fault_cnt_reg <= 9'h000;
            fault_reg     <= ~fault_reg;
        end
        else
        begin
            fault_cnt_reg <= fault_cnt_reg + 9'h001;
        end
    end

    assign fault_pin = fault_reg;

    // serial side runs on the host clock; select high clears it
    assign spi_arst = rst | ss_n;

    // mode 1: drive on rising edge, host samples on falling edge
    always_ff @(posedge sclk or posedge spi_arst)
    begin
        if (spi_arst)
        begin
            bit_cnt_reg <= 6'h00;
            miso_reg    <= 1'b0;
        end
        else if (bit_cnt_reg < 6'(FRAME_BITS))
        begin
            miso_reg    <= frame_reg[6'(FRAME_BITS - 1) - bit_cnt_reg];
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
        end
        else
        begin
            miso_reg <= 1'b0;
        end
    end

    assign miso_o    = miso_reg;
    assign miso_oe_n = ss_n;

    // helper for the toggle-rate check
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            since_tog_reg <= 16'h0000;
        else if (!ready_reg || err_any || fault_reg != $past(fault_reg))
            since_tog_reg <= 16'h0000;
        else
            since_tog_reg <= since_tog_reg + 16'h0001;
    end

    sequence s_clean_sample;
        ready_reg && sample_strobe && !err_any && sense_code == 16'sh0000;
    endsequence

    AST_STARTUP: assert property (@(posedge core_clk) disable iff (rst)
        !resn_sync_reg |=> !ready_reg ##1 !ready_reg)
        else $error("ready raised without a start-up interval");

    AST_MIDSCALE: assert property (@(posedge core_clk) disable iff (rst)
        s_clean_sample ##0 test_code == 16'sh0000 |=> wide_reg == MIDSCALE)
        else $error("zero current is not midscale");

    AST_TEST_GAIN: assert property (@(posedge core_clk) disable iff (rst)
        s_clean_sample ##0 test_code == 16'sh0001
        |=> wide_reg == 16'h800a)
        else $error("test coil gain is not ten");

    AST_NARROW: assert property (@(posedge core_clk) disable iff (rst)
        ready_reg && sample_strobe && wide_reg > narrow_acc_reg[23:NB_FRAC]
        |=> narrow_acc_reg >= $past(narrow_acc_reg))
        else $error("narrow word moves away from wide word");

    AST_NARROW_DOWN: assert property (@(posedge core_clk) disable iff (rst)
        ready_reg && sample_strobe && wide_reg < narrow_acc_reg[23:NB_FRAC]
        |=> narrow_acc_reg <= $past(narrow_acc_reg))
        else $error("narrow word rises above wide word");

    AST_ERR_WORD: assert property (@(posedge core_clk) disable iff (rst)
        ss_sync_reg && err_any |=> frame_reg.wide[15:6] == ERR_HIGH
        && !frame_reg.wide[2] && frame_reg.wide[3] == $past(hw_fault_reg))
        else $error("error pattern missing from wide word");

    AST_CRC: assert property (@(posedge core_clk) disable iff (rst)
        crc8(crc8(crc8(crc8(crc8(CRC_INIT, frame_reg[39:32]),
            frame_reg[31:24]), frame_reg[23:16]), frame_reg[15:8]),
            frame_reg[7:0]) == 8'h00)
        else $error("frame check byte is wrong");

    AST_FAULT_FREEZE: assert property (@(posedge core_clk) disable iff (rst)
        err_any |=> $stable(fault_reg))
        else $error("fault pin moved during a fault");

    AST_FAULT_IDLE: assert property (@(posedge core_clk) disable iff (rst)
        !ready_reg |=> $stable(fault_reg))
        else $error("fault pin moved during start-up");

    // helper sees a toggle one edge late, and a fresh start counts from
    // zero, so a full half period can read exactly the half count
    AST_FAULT_RATE: assert property (@(posedge core_clk) disable iff (rst)
        ready_reg && !err_any |-> since_tog_reg <= FAULT_HALF_I)
        else $error("fault pin toggles too slowly");

    AST_MSB_FIRST: assert property (@(posedge sclk) disable iff (spi_arst)
        bit_cnt_reg == 6'h00 |=> miso_reg == $past(frame_reg[39]))
        else $error("first bit out is not the wide word msb");

    AST_DESELECT: assert property (@(posedge core_clk) disable iff (rst)
        ss_n |-> miso_oe_n && !miso_o)
        else $error("miso driven while deselected");

endmodule

// >>> readout_pkg.sv
// constants, carriers and helper functions of the residual current readout
// Contract
// - chip select is active low; low selects for a transfer, high ends it.
// - reset pin low resets; data valid only after the start-up interval.
// - current leaves as a differential 48 MHz sigma-delta bitstream.
// - negative bitstream output is always the inverse of the positive one.
// - each frame carries a wide-band and a narrow-band 16-bit word.
// - narrow-band word is a 10 Hz filtered image of the 2 kHz wide word.
// - words are unsigned offset binary, zero current at midscale 32768.
// - fault pin toggles when healthy, freezes on any fault.
// - test-coil current appears multiplied by ten in the measurement.
// - serial port is half-duplex slave, mode 1, host makes select and clock.
// - five byte frame ends in CRC-8, poly 0x07, init 0xFF.
// - on error wide word has bits 15..6 set, bit 2 clear, flags low.
// - healthy fault pin toggles between 11 and 21 kHz.
package readout_pkg;

    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned STARTUP_MS    = 100;
    localparam int unsigned STARTUP_CYC   = CLK_HZ / 1000 * STARTUP_MS;
    localparam int unsigned FAULT_FREQ_HZ = 16_000;
    localparam int unsigned FAULT_HALF_CYC = CLK_HZ / (2 * FAULT_FREQ_HZ);
    localparam int unsigned BITSTREAM_HZ  = 48_000_000;

    localparam logic [15:0]       MIDSCALE     = 16'h8000;
    localparam logic signed [4:0] TEST_GAIN    = 5'sh0a;
    localparam logic [7:0]        CRC_POLY     = 8'h07;
    localparam logic [7:0]        CRC_INIT     = 8'hff;
    localparam int unsigned       FRAME_BITS   = 40;
    localparam logic [9:0]        ERR_HIGH     = 10'h3ff;
    localparam int unsigned       ERR_HIGH_LSB = 6;
    localparam int unsigned       ERR_ZERO_BIT = 2;
    localparam int unsigned       ERR_HW_BIT   = 3;
    localparam int unsigned       ERR_OOR_BIT  = 1;
    localparam int unsigned       ERR_CRIT_BIT = 0;
    localparam int unsigned       NB_SHIFT     = 8;
    localparam int unsigned       NB_FRAC      = 8;

    typedef struct packed {
        logic hw;
        logic over_range;
        logic critical;
    } fault_t;

    typedef struct packed {
        logic [15:0] wide;
        logic [15:0] narrow;
        logic [7:0]  crc;
    } frame_t;

    function automatic logic [7:0] crc8(input logic [7:0] crc_in,
                                        input logic [7:0] data_in);
        logic [7:0] d;
        d = crc_in ^ data_in;
        for (int i = 0; i < 8; i++)
        begin
            d = d[7] ? ({d[6:0], 1'b0} ^ CRC_POLY) : {d[6:0], 1'b0};
        end
        return d;
    endfunction

    // saturate a signed current and move zero to midscale
    function automatic logic [15:0] to_offset(input logic signed [19:0] v);
        if (v > 20'sh07fff)
            return 16'hffff;
        else if (v < -20'sh08000)
            return 16'h0000;
        else
            return v[15:0] ^ MIDSCALE;
    endfunction

    function automatic logic [15:0] err_word(input fault_t f);
        logic [15:0] w;
        w = 16'h0000;
        w[15:ERR_HIGH_LSB] = ERR_HIGH;
        w[ERR_ZERO_BIT] = 1'b0;
        w[ERR_HW_BIT]   = f.hw;
        w[ERR_OOR_BIT]  = f.over_range;
        w[ERR_CRIT_BIT] = f.critical;
        return w;
    endfunction

    function automatic frame_t frame_build(input logic [15:0] wide,
                                           input logic [15:0] narrow);
        frame_t fr;
        fr.wide   = wide;
        fr.narrow = narrow;
        fr.crc    = crc8(crc8(crc8(crc8(CRC_INIT, wide[15:8]), wide[7:0]),
                              narrow[15:8]), narrow[7:0]);
        return fr;
    endfunction

    localparam frame_t FRAME_IDLE = frame_build(MIDSCALE, MIDSCALE);

endpackage

// >>> sd_modulator.sv
// first-order sigma-delta modulator on the bitstream clock
`timescale 1ns/1ps
module sd_modulator (
    mod_clk,
    rst,
    word_in,
    word_toggle,
    bitstream_p,
    bitstream_n
);
    import readout_pkg::*;
    input  wire logic        mod_clk;
    input  wire logic        rst;
    input  wire logic [15:0] word_in;
    input  wire logic        word_toggle;
    output logic             bitstream_p;
    output logic             bitstream_n;

    logic        tog_meta_reg;
    logic        tog_sync_reg;
    logic        tog_prev_reg;
    logic [15:0] word_reg;
    logic [15:0] acc_reg;
    logic [16:0] acc_next;

    // toggle crossing; the word is held still by the core until captured
    always_ff @(posedge mod_clk or posedge rst)
    begin
        if (rst)
        begin
            tog_meta_reg <= 1'b0;
            tog_sync_reg <= 1'b0;
            tog_prev_reg <= 1'b0;
        end
        else
        begin
            tog_meta_reg <= word_toggle;
            tog_sync_reg <= tog_meta_reg;
            tog_prev_reg <= tog_sync_reg;
        end
    end

    always_ff @(posedge mod_clk or posedge rst)
    begin
        if (rst)
            word_reg <= MIDSCALE;
        else if (tog_sync_reg != tog_prev_reg)
            word_reg <= word_in;
    end

    assign acc_next = {1'b0, acc_reg} + {1'b0, word_reg};

    // carry out is the bit; its density equals word over full scale
    always_ff @(posedge mod_clk or posedge rst)
    begin
        if (rst)
        begin
            acc_reg     <= 16'h0000;
            bitstream_p <= 1'b0;
            bitstream_n <= 1'b1;
        end
        else
        begin
            acc_reg     <= acc_next[15:0];
            bitstream_p <= acc_next[16];
            bitstream_n <= ~acc_next[16];
        end
    end

    AST_NEG_INV: assert property (@(posedge mod_clk) disable iff (rst)
        bitstream_n == ~bitstream_p)
        else $error("negative bitstream is not the inverse");

    AST_MOD_CAPTURE: assert property (@(posedge mod_clk) disable iff (rst)
        (tog_sync_reg != tog_prev_reg) |=> word_reg == $past(word_in))
        else $error("modulator missed a new word");

    AST_MOD_FULL: assert property (@(posedge mod_clk) disable iff (rst)
        (word_reg == 16'h0000) [*3] |-> !bitstream_p)
        else $error("zero word produced a one bit");

endmodule

// >>> spi_host_model.sv
// host side model: spi master that reads one five byte frame in mode 1
`timescale 1ns/1ps
module spi_host_model (
    output logic      sclk,
    output logic      ss_n,
    input  wire logic miso
);
    initial
    begin
        sclk = 1'b0;
        ss_n = 1'b1;
    end

    // clock runs only inside a frame and idles low between frames
    task automatic read_frame(output logic [39:0] fr);
        fr = '0;
        ss_n = 1'b0;
        #400;
        for (int i = 39; i >= 0; i--)
        begin
            #6 sclk = 1'b1;
            #6 sclk = 1'b0;
            fr[i] = miso;
        end
        #150 ss_n = 1'b1;
        #300;
    endtask
endmodule

// >>> testbench.sv
// self-checking bench for the residual current readout port
`timescale 1ns/1ps
module testbench;
    import readout_pkg::*;
    localparam int STARTUP = 20;
    logic               core_clk, rst, reset_n, mod_clk, sclk, ss_n;
    logic               sample_strobe, miso_o, miso_oe_n, fault_pin, ready;
    logic               bitstream_p, bitstream_n;
    logic signed [15:0] sense_code, test_code;
    fault_t             fault_in;
    logic [39:0]        fr;
    logic [15:0]        w_last, n_last;
    int                 bad_count, n_checks, c;
    int                 cyc = 0;
    int                 ones = 0;
    int                 total = 0;
    int                 ones_n = 0;
    int                 offset = 0;
    int                 ana_off = 0;

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial
    begin
        mod_clk = 1'b0;
        #3.1;
        forever #10.417 mod_clk = ~mod_clk;
    end

    residual_current_readout_port #(.STARTUP_CYCLES(STARTUP))
        residual_current_readout_port_i (
        .core_clk      (core_clk),
        .rst           (rst),
        .reset_n       (reset_n),
        .mod_clk       (mod_clk),
        .sclk          (sclk),
        .ss_n          (ss_n),
        .sense_code    (sense_code),
        .test_code     (test_code),
        .sample_strobe (sample_strobe),
        .fault_in      (fault_in),
        .miso_o        (miso_o),
        .miso_oe_n     (miso_oe_n),
        .bitstream_p   (bitstream_p),
        .bitstream_n   (bitstream_n),
        .fault_pin     (fault_pin),
        .ready         (ready)
    );

    spi_host_model spi_host_model_i (
        .sclk (sclk),
        .ss_n (ss_n),
        .miso (miso_o)
    );

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #10;
    endtask

    // own bitwise crc, deliberately independent of the design's helper
    function automatic logic [7:0] crc_bits(input logic [39:0] d);
        logic [7:0] k;
        k = 8'hff;
        for (int i = 39; i >= 0; i--)
            k = {k[6:0], 1'b0} ^ ((k[7] ^ d[i]) ? 8'h07 : 8'h00);
        return k;
    endfunction

    task automatic frame_check(input logic [15:0] wide_exp);
        spi_host_model_i.read_frame(fr);
        chk(fr[39:24], wide_exp, "wide word");
        chk({8'h00, crc_bits(fr)}, 16'h0000, "frame crc");
        tick(1);
    endtask

    // narrow filter steps toward the wide word held before this strobe
    task automatic sample(input int s, input int t);
        int v, vc, cur;
        logic [15:0] w, lo, hi, nv;
        v = s + 10 * t;
        vc = v > 32767 ? 32767 : v < -32768 ? -32768 : v;
        w = 16'(vc + 32768);
        sense_code = 16'(s);
        test_code = 16'(t);
        sample_strobe = 1'b1;
        tick(1);
        sample_strobe = 1'b0;
        tick(5);
        frame_check(w);
        cur = int'(fr[39:24]) - 32768 - offset;
        chk(16'(cur), 16'(vc), "host current");
        lo = n_last < w_last ? n_last : w_last;
        hi = n_last < w_last ? w_last : n_last;
        nv = fr[23:8];
        chk(nv < lo ? lo : nv > hi ? hi : nv, nv, "narrow word");
        w_last = w;
        n_last = nv;
    endtask

    task automatic wait_ready();
        logic f;
        int moved;
        f = fault_pin;
        moved = 0;
        c = 0;
        while (ready !== 1'b1 && c < 60)
        begin
            tick(1);
            c++;
            moved += int'(fault_pin !== f);
        end
        chk(16'(moved), 16'h0000, "fault pin moved in start-up");
        chk(16'(c < STARTUP ? 0 : c > STARTUP + 5 ? 0 : 1), 16'h0001,
            "start-up length");
    endtask

    task automatic frozen(input int n);
        logic f;
        int k;
        f = fault_pin;
        k = 0;
        repeat (n)
        begin
            tick(1);
            k += int'(fault_pin !== f);
        end
        chk(16'(k), 16'h0000, "fault pin moved under fault");
    endtask

    task automatic toggle_check();
        logic f;
        for (int j = 0; j < 2; j++)
        begin
            f = fault_pin;
            c = 0;
            while (fault_pin === f && c < 1000)
            begin
                tick(1);
                c++;
            end
        end
        chk(16'(c), 16'(FAULT_HALF_CYC), "fault half period");
    endtask

    // ones density of both streams over 4096 modulator bits, counted alike
    task automatic dens(input int word);
        int t0, o0, n0, g, gn, d, e;
        tick(20);
        t0 = total;
        o0 = ones;
        n0 = ones_n;
        wait (total >= t0 + 4096);
        g = ones - o0;
        gn = ones_n - n0;
        e = word / 16;
        chk(16'(g < e - 8 ? e - 8 : g > e + 8 ? e + 8 : g), 16'(g),
            "bitstream density");
        chk(16'(g + gn), 16'(total - t0), "stream pair");
        if (word == 32768)
            ana_off = g - gn;
        d = g - gn - ana_off - (2 * e - 4096);
        chk(16'(d < -16 ? -16 : d > 16 ? 16 : d), 16'(d),
            "compensated differential");
    endtask

    always @(posedge mod_clk)
    begin
        total <= total + 1;
        ones <= ones + int'(bitstream_p);
        ones_n <= ones_n + int'(bitstream_n);
        if (!rst)
            chk({15'h0, bitstream_n}, {15'h0, ~bitstream_p},
                "negative stream");
    end

    // host clock only moves inside a frame, so the pin must be driven
    always @(negedge sclk)
    begin
        if (ss_n === 1'b0)
            chk({15'h0, miso_oe_n}, 16'h0000, "miso enable");
    end

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            final_report();
        end
    end

    initial
    begin
        rst = 1'b1;
        reset_n = 1'b0;
        sample_strobe = 1'b0;
        sense_code = '0;
        test_code = '0;
        fault_in = '0;
        bad_count = 0;
        n_checks = 0;
        n_last = MIDSCALE;
        w_last = MIDSCALE;
        void'($urandom(32'h6c0a));
        tick(4);
        rst = 1'b0;
        reset_n = 1'b1;
        // strobe before ready must be ignored
        sense_code = 16'sd1000;
        sample_strobe = 1'b1;
        tick(1);
        sample_strobe = 1'b0;
        wait_ready();
        frame_check(MIDSCALE);
        offset = int'(fr[23:8]) - 32768;
        toggle_check();
        dens(32768);
        repeat (8)
            sample(int'($urandom_range(65535)) - 32768,
                   int'($urandom_range(200)) - 100);
        sample(32767, 1);
        sample(-32768, -1);
        sample(0, 1);
        sample(0, 0);
        for (int i = 0; i < 3; i++)
        begin
            fault_in = fault_t'(3'b001 << i);
            tick(5);
            frozen(700);
            frame_check(16'hffc0 | (i == 2 ? 16'h0008 : 16'h0001 << i));
            if (i == 1)
                dens(65474);
            fault_in = '0;
            tick(5);
            frame_check(i == 2 ? 16'hffc8 : w_last);
        end
        frozen(400);
        reset_n = 1'b0;
        c = 0;
        while (ready !== 1'b0 && c < 10)
        begin
            tick(1);
            c++;
        end
        chk({15'h0, ready}, 16'h0000, "ready after reset pin");
        reset_n = 1'b1;
        rst = 1'b1;
        tick(4);
        rst = 1'b0;
        n_last = MIDSCALE;
        w_last = MIDSCALE;
        wait_ready();
        frame_check(MIDSCALE);
        offset = int'(fr[23:8]) - 32768;
        toggle_check();
        final_report();
    end
endmodule
